/* logic/eg_pkg.sv */
// Shared constants and types of the write-command guard.
// Assumes a 10 MHz system clock and an SPI mode 0 link clock.
package eg_pkg;

    // System clock and self-timed program cycle
    localparam int CLK_PERIOD_NS = 100;
    localparam int PROG_TIME_NS  = 5000000;
    localparam int PROG_CYCLES   =
        (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Instruction opcodes
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_READ   = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
    localparam logic [7:0] OP_ARRAY_READ    = 8'h03;
    localparam logic [7:0] OP_ARRAY_WRITE   = 8'h02;

    // Frame bit counts
    localparam logic [15:0] OPCODE_BITS      = 16'h0008;
    localparam logic [15:0] STATUS_WR_BITS   = 16'h0010;
    localparam logic [15:0] ARRAY_WR_MIN     = 16'h0020;
    localparam logic [15:0] BIT_CNT_MAX      = 16'hFFFF;

    // Status byte layout
    localparam int         SR_READY_BIT = 0;
    localparam int         SR_LATCH_BIT = 1;
    localparam logic [7:0] SR_IDLE_BASE = 8'h00;
    localparam logic [7:0] SR_BUSY_FILL = 8'hFF;

    // Command decided by the link side, taken at chip select rise
    typedef enum logic [2:0] {
        EG_CMD_NONE,
        EG_CMD_WR_ENABLE,
        EG_CMD_WR_DISABLE,
        EG_CMD_ARRAY_WR,
        EG_CMD_STATUS_WR
    } eg_cmd_e;

    // Guard states
    typedef enum logic [1:0] {
        EG_ST_STANDBY,
        EG_ST_SELECTED,
        EG_ST_PROGRAM
    } eg_state_e;

endpackage

/* logic/eg_core_if.sv */
// Carrier between the top module and the program-cycle controller.
// Assumes all members live in the ref_clk domain.
`timescale 1ns/100ps
interface eg_core_if;
    import eg_pkg::*;
    eg_cmd_e cmd;
    logic    frame_end;
    logic    selected;
    logic    busy;
    logic    wr_latch;
    logic    standby;

    modport ctl (input  cmd, frame_end, selected,
                 output busy, wr_latch, standby);
    modport top (output cmd, frame_end, selected,
                 input  busy, wr_latch, standby);
endinterface

/* logic/eg_prog_ctl.sv */
// Standby, write-enable latch and self-timed program cycle control.
// Assumes synchronised, ref_clk-domain inputs from the top module.
`timescale 1ns/100ps
module eg_prog_ctl #(
    parameter int PROG_CNT = eg_pkg::PROG_CYCLES
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Core side
    eg_core_if.ctl    core
);
    import eg_pkg::*;

    localparam int CW = $clog2(PROG_CNT + 1);
    localparam logic [CW-1:0] CNT_LOAD = CW'(PROG_CNT - 1);

    eg_state_e     state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          latch_q, latch_d;
    logic          busy_q, busy_d;
    logic          standby_q, standby_d;

    // Next state of the guard
    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        latch_d   = latch_q;
        case (state_q)
            EG_ST_STANDBY: begin
                if (core.selected) begin
                    state_d = EG_ST_SELECTED;
                end
            end
            EG_ST_SELECTED: begin
                if (core.frame_end) begin
                    state_d = EG_ST_STANDBY;
                    case (core.cmd)
                        EG_CMD_WR_ENABLE:  latch_d = 1'b1;
                        EG_CMD_WR_DISABLE: latch_d = 1'b0;
                        EG_CMD_ARRAY_WR, EG_CMD_STATUS_WR: begin
                            if (latch_q) begin
                                state_d = EG_ST_PROGRAM;
                                cnt_d   = CNT_LOAD;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            EG_ST_PROGRAM: begin
                // Frames seen here are ignored
                if (cnt_q == '0) begin
                    state_d = EG_ST_STANDBY;
                    latch_d = 1'b0;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            default: state_d = EG_ST_STANDBY;
        endcase
        busy_d    = (state_d == EG_ST_PROGRAM);
        standby_d = (state_d == EG_ST_STANDBY);
    end

    // Guard registers, set to standby with latch, busy and count cleared while power-on reset holds
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q   <= EG_ST_STANDBY;
            cnt_q     <= '0;
            latch_q   <= 1'b0;
            busy_q    <= 1'b0;
            standby_q <= 1'b1;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            latch_q   <= latch_d;
            busy_q    <= busy_d;
            standby_q <= standby_d;
        end
    end

    assign core.busy    = busy_q;
    assign core.wr_latch = latch_q;
    assign core.standby = standby_q;
endmodule

/* logic/eg_guard_top.sv */
// Power-up and command-acceptance guard of a serial EEPROM.
// Assumes an SPI mode 0 host; rst is the power-on reset indication.
// Assumes spi_sck stands still while chip select is high.
// Assumes chip select stays high for at least four ref_clk cycles.
//
// Summary of operation
// - Release of power-on reset leaves standby with all logic idle.
// - While power-on reset holds, logic stays reset and takes no command.
// - Power-on reset clears the write-enable latch; writes need it set.
// - An instruction is taken only after chip select has gone low.
// - Completed array or status write clears the write-enable latch.
// - Program cycle starts only on chip select rise after exact clocks.
// - Array accesses during a program cycle are ignored; programming runs on.
// - Unknown opcode does nothing; data output stays high impedance.
// - Status read works any time outside power-on reset; while busy it returns all ones.
// - Busy reads 1 throughout the program cycle, 0 when ready.
`timescale 1ns/100ps
module eg_guard_top #(
    parameter int PROG_CNT = eg_pkg::PROG_CYCLES
) (
    // System clock and power-on reset
    input  wire logic           ref_clk,
    input  wire logic           rst,
    // SPI link
    input  wire logic           spi_sck,
    input  wire logic           spi_cs_n,
    input  wire logic           spi_si,
    output logic                spi_so,
    output logic                spi_so_oe_n,
    // Status
    output logic                standby,
    output logic                busy,
    output logic                write_enable_latch
);
    import eg_pkg::*;

    eg_core_if core_if ();

    // Link-side state
    logic [15:0] cnt_q, cnt_d;
    logic [7:0]  shift_q, shift_d;
    logic [7:0]  op_q, op_d;
    logic        live_q, live_d;
    logic        stat_rd_q, stat_rd_d;
    eg_cmd_e     cmd_q, cmd_d;
    logic        so_q, so_d;
    logic        so_oe_n_q, so_oe_n_d;
    logic [7:0]  stat;
    logic        frame_rst;
    logic        frame_tgl_q, frame_tgl_d;

    // Link-side copies of the controller's levels
    logic        busy_s1_q, busy_s2_q;
    logic        latch_s1_q, latch_s2_q;

    // System-side copies of link signals
    logic        cs_s1_q, cs_s2_q, cs_s3_q;
    eg_cmd_e     cmd_s1_q, cmd_s2_q;
    logic        tgl_s1_q, tgl_s2_q;
    logic        tgl_used_q, tgl_used_d;
    logic        cmd_fresh;

    // Per-frame link state clears whenever chip select is high
    assign frame_rst = rst | spi_cs_n;

    // Opcodes that act on the latch at once; all others decide nothing
    function automatic eg_cmd_e latch_cmd(input logic [7:0] op);
        eg_cmd_e c;
        case (op)
            OP_WRITE_ENABLE:  c = EG_CMD_WR_ENABLE;
            OP_WRITE_DISABLE: c = EG_CMD_WR_DISABLE;
            default:          c = EG_CMD_NONE;
        endcase
        return c;
    endfunction

    // Bit count, opcode capture and command decision
    always_comb begin
        cnt_d   = (cnt_q == BIT_CNT_MAX) ? cnt_q : cnt_q + 16'h0001;
        shift_d = {shift_q[6:0], spi_si};
        op_d    = op_q;
        live_d  = live_q;
        stat_rd_d = stat_rd_q;
        cmd_d   = EG_CMD_NONE;
        // Flips at the first clock of a frame, marks a fresh decision
        frame_tgl_d = (cnt_q == 16'h0000) ? ~frame_tgl_q : frame_tgl_q;
        if (cnt_d == OPCODE_BITS) begin
            op_d   = shift_d;
            // Only status read gets through a program cycle
            live_d = ~busy_s2_q;
            stat_rd_d = (shift_d == OP_STATUS_READ);
            // Writes wait for their length; latch opcodes decide here
            if (~busy_s2_q) begin
                cmd_d = latch_cmd(shift_d);
            end
        end else if (live_q && op_q == OP_STATUS_WRITE) begin
            if (cnt_d == STATUS_WR_BITS) begin
                cmd_d = EG_CMD_STATUS_WR;
            end
        end else if (live_q && op_q == OP_ARRAY_WRITE) begin
            if (cnt_d >= ARRAY_WR_MIN && cnt_d[2:0] == 3'h0) begin
                cmd_d = EG_CMD_ARRAY_WR;
            end
        end
    end

    // Per-frame link registers
    always_ff @(posedge spi_sck or posedge frame_rst) begin
        if (frame_rst) begin
            cnt_q   <= 16'h0000;
            shift_q <= 8'h00;
            op_q    <= 8'h00;
            live_q  <= 1'b0;
            stat_rd_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            shift_q <= shift_d;
            op_q    <= op_d;
            live_q  <= live_d;
            stat_rd_q <= stat_rd_d;
        end
    end

    // Decided command survives chip select rise
    always_ff @(posedge spi_sck or posedge rst) begin
        if (rst) begin
            cmd_q       <= EG_CMD_NONE;
            frame_tgl_q <= 1'b0;
            busy_s1_q   <= 1'b0;
            busy_s2_q   <= 1'b0;
            latch_s1_q  <= 1'b0;
            latch_s2_q  <= 1'b0;
        end else begin
            cmd_q       <= cmd_d;
            frame_tgl_q <= frame_tgl_d;
            busy_s1_q   <= core_if.busy;
            busy_s2_q   <= busy_s1_q;
            latch_s1_q  <= core_if.wr_latch;
            latch_s2_q  <= latch_s1_q;
        end
    end

    // Status byte as seen by the host
    always_comb begin
        stat               = SR_IDLE_BASE;
        stat[SR_LATCH_BIT] = latch_s2_q;
        stat[SR_READY_BIT] = busy_s2_q;
        if (busy_s2_q) begin
            stat = SR_BUSY_FILL;
        end
    end

    // Serial output, most significant bit first, launched on falling edge
    always_comb begin
        so_d      = stat[~cnt_q[2:0]];
        so_oe_n_d = ~stat_rd_q;
    end

    // Output drivers, released whenever chip select is high
    always_ff @(negedge spi_sck or posedge frame_rst) begin
        if (frame_rst) begin
            so_q      <= 1'b0;
            so_oe_n_q <= 1'b1;
        end else begin
            so_q      <= so_d;
            so_oe_n_q <= so_oe_n_d;
        end
    end

    // Chip select and command brought into the system clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            cs_s3_q  <= 1'b1;
            cmd_s1_q <= EG_CMD_NONE;
            cmd_s2_q <= EG_CMD_NONE;
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_used_q <= 1'b0;
        end else begin
            cs_s1_q  <= spi_cs_n;
            cs_s2_q  <= cs_s1_q;
            cs_s3_q  <= cs_s2_q;
            cmd_s1_q <= cmd_q;
            cmd_s2_q <= cmd_s1_q;
            tgl_s1_q <= frame_tgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_used_q <= tgl_used_d;
        end
    end

    // A decision counts once; a select with no clock repeats nothing
    always_comb begin
        cmd_fresh  = (tgl_s2_q != tgl_used_q);
        tgl_used_d = core_if.frame_end ? tgl_s2_q : tgl_used_q;
    end

    // Select level and rise event toward the controller
    assign core_if.selected  = ~cs_s2_q;
    assign core_if.frame_end = cs_s2_q & ~cs_s3_q;
    assign core_if.cmd       = cmd_fresh ? cmd_s2_q : EG_CMD_NONE;

    // Program-cycle controller
    eg_prog_ctl #(
        .PROG_CNT (PROG_CNT)
    ) u_prog_ctl (
        .ref_clk (ref_clk),
        .rst     (rst),
        .core    (core_if)
    );

    // Pin and status outputs
    assign spi_so             = so_q;
    assign spi_so_oe_n        = so_oe_n_q;
    assign standby            = core_if.standby;
    assign busy               = core_if.busy;
    assign write_enable_latch = core_if.wr_latch;
endmodule

/* tb/eg_guard_props.sv */
// Port checker of the write-command guard.
// Assumes binding to eg_guard_top; all checks in the ref_clk domain.
`timescale 1ns/100ps
module eg_guard_props #(
    parameter int PROG_CNT = eg_pkg::PROG_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // SPI link
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    input wire logic spi_so,
    input wire logic spi_so_oe_n,
    // Status
    input wire logic standby,
    input wire logic busy,
    input wire logic write_enable_latch
);
    import eg_pkg::*;
    logic [15:0] run_q;
    logic [15:0] run_d;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Length of the current busy run
    always_comb run_d = busy ? run_q + 16'h0001 : 16'h0000;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) run_q <= 16'h0000;
        else run_q <= run_d;
    end

    a_reset_idle: assert property (disable iff (1'b0)
        rst |-> standby && !busy && !write_enable_latch && spi_so_oe_n)
        else $error("guard not idle in reset");
    a_busy_no_standby: assert property (busy |-> !standby)
        else $error("standby while busy");
    a_prog_on_rise: assert property ($rose(busy) |->
        $past(spi_cs_n, 1) && $past(spi_cs_n, 3))
        else $error("program started while selected");
    a_busy_holds: assert property ($rose(busy) |=> busy [*8])
        else $error("program cycle cut short");
    a_busy_length: assert property ($fell(busy) |->
        run_q == 16'(PROG_CNT))
        else $error("program cycle length wrong");
    a_done_clears_wel: assert property ($fell(busy) |->
        !write_enable_latch && standby)
        else $error("latch kept after program");
    a_wel_after_frame: assert property ($rose(write_enable_latch) |->
        $past(spi_cs_n, 3))
        else $error("latch set inside a frame");
    a_quiet_deselect: assert property (spi_cs_n |-> spi_so_oe_n)
        else $error("data out driven while deselected");

    c_program: cover property ($rose(busy));
    c_latch: cover property ($rose(write_enable_latch));
    c_so_drive: cover property ($fell(spi_so_oe_n));
endmodule

/* tb/eg_spi_host.sv */
// SPI mode 0 host model for the command guard.
// Assumes the guard samples on sck rise and drives on sck fall.
`timescale 1ns/100ps
module eg_spi_host (
    // SPI link
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_si,
    input  wire logic spi_so,
    input  wire logic spi_so_oe_n
);
    // Idle link: clock stands low, device deselected
    initial begin
        spi_sck  = 1'b0;
        spi_si   = 1'b0;
        // Late select rise so the reset pulse reaches the link flops
        #2 spi_cs_n = 1'b1;
    end

    // One frame of n bits, MSB first, closed by select rise
    task automatic xfer(input logic [63:0] d, input int n,
                        output logic [7:0] rx, output logic drv);
        drv = 1'b0;
        rx = 8'h00;
        spi_cs_n = 1'b0;
        #31;
        for (int i = n - 1; i >= 0; i--) begin
            spi_si = d[i];
            #62.5 spi_sck = 1'b1;
            // A released output reads back inverted, never as data
            rx = {rx[6:0], spi_so_oe_n ? ~spi_so : spi_so};
            drv = drv | !spi_so_oe_n;
            #62.5 spi_sck = 1'b0;
        end
        #62.5 spi_cs_n = 1'b1;
        spi_si = ~spi_si;
    endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench of the write-command guard.
// Assumes eg_pkg, the guard design and the host model are compiled first.
`timescale 1ns/100ps
module tb_top;
    import eg_pkg::*;
    localparam int PROG_CNT = 100;
    logic ref_clk = 1'b0;
    logic rst = 1'b0;
    logic sck, cs_n, si, so, oe_n, standby, busy, latch, drv;
    logic [7:0] rx, op;
    logic [63:0] d;
    int n;
    int error_cnt = 0;
    int compares = 0;
    int seed = 32249;

    // System clock
    always #50 ref_clk = ~ref_clk;

    eg_spi_host host (.spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si),
        .spi_so(so), .spi_so_oe_n(oe_n));
    eg_guard_top #(.PROG_CNT(PROG_CNT)) uut (.ref_clk(ref_clk), .rst(rst),
        .spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si), .spi_so(so),
        .spi_so_oe_n(oe_n), .standby(standby), .busy(busy),
        .write_enable_latch(latch));

    // Comparison and verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d, compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [7:0] sr_exp(input logic b, input logic w);
        return b ? SR_BUSY_FILL : (SR_IDLE_BASE | {6'h00, w, 1'b0});
    endfunction

    // Frame helpers and flag checks
    task automatic frame(input logic [63:0] v, input int bits);
        host.xfer(v, bits, rx, drv);
        repeat (8) @(negedge ref_clk);
    endtask
    task automatic fl(input logic s, input logic b, input logic w);
        chk({5'h00, standby, busy, latch}, {5'h00, s, b, w});
    endtask
    task automatic st(input logic b, input logic w);
        frame({48'h0, OP_STATUS_READ, 8'h00}, 16);
        chk(rx, sr_exp(b, w));
    endtask

    // Watchdog
    initial begin
        #500000;
        error_cnt++;
        end_of_test();
    end

    // Main sequence
    initial begin
        // Reset rises after time zero so every flop sees the edge
        #1 rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        fl(1'b1, 1'b0, 1'b0);
        st(1'b0, 1'b0);
        frame({40'h0, OP_ARRAY_WRITE, 16'h0010, 8'h5A}, 32);
        fl(1'b1, 1'b0, 1'b0);
        frame({56'h0, OP_WRITE_ENABLE}, 8);
        st(1'b0, 1'b1);
        frame({56'h0, OP_WRITE_DISABLE}, 8);
        fl(1'b1, 1'b0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            op = 8'($random(seed));
            if (op[7:3] == 5'h00) op[7] = 1'b1;
            frame({48'h0, op, 8'h00}, 16);
            chk({7'h00, drv}, 8'h00);
            fl(1'b1, 1'b0, 1'b0);
        end
        frame({56'h0, OP_WRITE_ENABLE}, 8);
        frame({31'h0, OP_ARRAY_WRITE, 25'h0}, 33);
        fl(1'b1, 1'b0, 1'b1);
        for (int k = 0; k < 3; k++) begin
            frame({56'h0, OP_WRITE_ENABLE}, 8);
            d = {32'($random(seed)), 32'($random(seed))};
            n = (k == 2) ? 16 : 32 + 8 * (($random(seed) & 3));
            d[n - 1 -: 8] = (k == 2) ? OP_STATUS_WRITE : OP_ARRAY_WRITE;
            frame(d, n);
            fl(1'b0, 1'b1, 1'b1);
            st(1'b1, 1'b1);
            frame({40'h0, OP_ARRAY_WRITE, 24'h0}, 32);
            for (int t = 0; t < 2 * PROG_CNT && busy !== 1'b0; t++)
                @(negedge ref_clk);
            repeat (8) @(negedge ref_clk);
            fl(1'b1, 1'b0, 1'b0);
        end
        frame({56'h0, OP_WRITE_ENABLE}, 8);
        rst = 1'b1;
        host.xfer({56'h0, OP_WRITE_ENABLE}, 8, rx, drv);
        @(negedge ref_clk);
        fl(1'b1, 1'b0, 1'b0);
        rst = 1'b0;
        repeat (8) @(negedge ref_clk);
        fl(1'b1, 1'b0, 1'b0);
        end_of_test();
    end
endmodule

bind eg_guard_top eg_guard_props #(.PROG_CNT(PROG_CNT)) u_props (
    .ref_clk(ref_clk), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n),
    .standby(standby), .busy(busy),
    .write_enable_latch(write_enable_latch));
